/* File: hdl/sag_top.sv */
// Segmented address generator: size, segment, linear and physical address
`timescale 1ns/1ns
`default_nettype none
`include "sag_regs.svh"
module sag_top
  import sag_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Mode and control state
  input  wire logic        real_mode,
  input  wire logic [31:0] ctrl_reg0,
  input  wire logic        desc_default_big,
  // Prefixes
  input  wire logic        op_len_prefix,
  input  wire logic        addr_len_prefix,
  input  wire logic        ovr_en,
  input  wire logic [2:0]  ovr_seg,
  // Request
  input  wire logic        req_valid,
  input  wire logic [2:0]  ref_kind,
  input  wire logic [31:0] instr_ptr,
  input  wire logic        base_en,
  input  wire logic [2:0]  base_sel,
  input  wire logic [31:0] base_val,
  input  wire logic        index_en,
  input  wire logic [2:0]  index_sel,
  input  wire logic [31:0] index_val,
  input  wire logic [1:0]  scale_log2,
  input  wire logic [1:0]  disp_size,
  input  wire logic [31:0] disp_val,
  // Segment bases and selectors, six of each
  input  wire logic [191:0] seg_base_flat,
  input  wire logic [95:0]  seg_selector_flat,
  // Results
  output logic             req_ready,
  output logic             out_valid,
  output logic [2:0]       out_seg,
  output logic [31:0]      out_offset,
  output logic [31:0]      out_linear,
  output logic [23:0]      out_phys,
  output logic             out_to_pager,
  output logic             out_gp_fault,
  output logic             out_form_bad,
  output logic             out_op32,
  output logic             out_addr32
);
  typedef enum logic [0:0] {SAG_IDLE, SAG_EXTRA} sag_state_t;

  logic        def_big;
  logic        op32;
  logic        addr32;
  logic        is_fetch;
  logic [2:0]  seg_sel;
  logic [31:0] ea;
  logic        bad;
  logic [31:0] offset;
  logic [31:0] linear;
  logic        paging;
  logic        gp_fault;
  logic        need_extra;
  logic [31:0] seg_base [0:5];
  logic [15:0] seg_selr [0:5];

  sag_state_t  state_r,    state_nxt;
  logic        ready_r,    ready_nxt;
  logic        valid_r,    valid_nxt;
  logic [2:0]  seg_r,      seg_nxt;
  logic [31:0] off_r,      off_nxt;
  logic [31:0] lin_r,      lin_nxt;
  logic [23:0] phys_r,     phys_nxt;
  logic        pager_r,    pager_nxt;
  logic        gp_r,       gp_nxt;
  logic        bad_r,      bad_nxt;
  logic        op32_r,     op32_nxt;
  logic        a32_r,      a32_nxt;

  // Unpack the segment file
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_seg
      assign seg_base[g] = seg_base_flat[g*32 +: 32];
      assign seg_selr[g] = seg_selector_flat[g*16 +: 16];
    end
  endgenerate

  // Sizes: real mode forces 16, else descriptor bit; prefixes invert
  assign def_big = real_mode ? 1'b0 : desc_default_big;
  assign op32    = def_big ^ op_len_prefix;
  assign addr32  = def_big ^ addr_len_prefix;
  assign is_fetch = (ref_kind == SAG_REF_FETCH);

  sag_seg_select u_seg
  (
    .ref_kind (ref_kind),
    .base_en  (base_en),
    .base_sel (base_sel),
    .addr32   (addr32),
    .ovr_en   (ovr_en),
    .ovr_seg  (ovr_seg),
    .seg_sel  (seg_sel)
  );

  sag_offset_calc u_off
  (
    .base_en          (base_en),
    .base_val         (base_val),
    .index_en         (index_en),
    .index_sel        (index_sel),
    .index_val        (index_val),
    .scale_log2       (scale_log2),
    .disp_size        (disp_size),
    .disp_val         (disp_val),
    .addr32           (addr32),
    .effective_offset (ea),
    .form_bad         (bad)
  );

  // Linear address and paging path
  always_comb
  begin
    offset = is_fetch ? instr_ptr : ea;
    if (real_mode)
      linear = ({16'h0000, seg_selr[seg_sel]} << `SAG_REAL_SHIFT) + offset;
    else
      linear = seg_base[seg_sel] + offset;
    paging   = !real_mode && ctrl_reg0[`SAG_PG_BIT];
    // Fetch offsets are not checked here; the fetch unit owns that
    gp_fault = real_mode && !is_fetch && (offset > `SAG_REAL_LIMIT);
    need_extra = !is_fetch && base_en && index_en;
  end

  // Handshake and result capture; base plus index on a non-fetch holds one more clock
  always_comb
  begin
    state_nxt = state_r;
    ready_nxt = ready_r;
    valid_nxt = 1'b0;
    seg_nxt   = seg_r;
    off_nxt   = off_r;
    lin_nxt   = lin_r;
    phys_nxt  = phys_r;
    pager_nxt = pager_r;
    gp_nxt    = gp_r;
    bad_nxt   = bad_r;
    op32_nxt  = op32_r;
    a32_nxt   = a32_r;
    unique case (state_r)
      SAG_IDLE:
      begin
        ready_nxt = 1'b1;
        if (req_valid && ready_r)
        begin
          seg_nxt   = seg_sel;
          off_nxt   = offset;
          lin_nxt   = linear;
          phys_nxt  = linear[`SAG_PHYS_BITS-1:0];
          pager_nxt = paging;
          gp_nxt    = gp_fault;
          bad_nxt   = bad;
          op32_nxt  = op32;
          a32_nxt   = addr32;
          if (need_extra)
          begin
            state_nxt = SAG_EXTRA;
            ready_nxt = 1'b0;
          end
          else
            valid_nxt = 1'b1;
        end
      end
      SAG_EXTRA:
      begin
        valid_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = SAG_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_r <= SAG_IDLE;
      ready_r <= 1'b0;
      valid_r <= 1'b0;
      seg_r   <= 3'h0;
      off_r   <= 32'h00000000;
      lin_r   <= 32'h00000000;
      phys_r  <= 24'h000000;
      pager_r <= 1'b0;
      gp_r    <= 1'b0;
      bad_r   <= 1'b0;
      op32_r  <= 1'b0;
      a32_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      valid_r <= valid_nxt;
      seg_r   <= seg_nxt;
      off_r   <= off_nxt;
      lin_r   <= lin_nxt;
      phys_r  <= phys_nxt;
      pager_r <= pager_nxt;
      gp_r    <= gp_nxt;
      bad_r   <= bad_nxt;
      op32_r  <= op32_nxt;
      a32_r   <= a32_nxt;
    end
  end

  assign req_ready    = ready_r;
  assign out_valid    = valid_r;
  assign out_seg      = seg_r;
  assign out_offset   = off_r;
  assign out_linear   = lin_r;
  assign out_phys     = phys_r;
  assign out_to_pager = pager_r;
  assign out_gp_fault = gp_r;
  assign out_form_bad = bad_r;
  assign out_op32     = op32_r;
  assign out_addr32   = a32_r;
endmodule
`default_nettype wire

/* File: hdl/sag_regs.svh */
// Constants for the segmented address generator
`ifndef SAG_REGS_SVH
`define SAG_REGS_SVH
`define SAG_PHYS_BITS      24
`define SAG_PG_BIT         31
`define SAG_REAL_SHIFT     4
`define SAG_REAL_LIMIT     32'h0000FFFF
`define SAG_EXTRA_CYCLES   1
`define SAG_GPR_SP         3'h4
`define SAG_GPR_BP         3'h5
`define SAG_GPR_BX         3'h3
`define SAG_GPR_SI         3'h6
`define SAG_GPR_DI         3'h7
`endif

/* File: hdl/sag_pkg.sv */
// Types shared by the segmented address generator
package sag_pkg;
  // Segment numbering follows the selector file order
  typedef enum logic [2:0] {
    SAG_SEG_EXTRA = 3'h0,
    SAG_SEG_CODE  = 3'h1,
    SAG_SEG_STACK = 3'h2,
    SAG_SEG_DATA  = 3'h3,
    SAG_SEG_AUX1  = 3'h4,
    SAG_SEG_AUX2  = 3'h5
  } sag_seg_t;
  // Kind of memory reference the pipeline asks for
  typedef enum logic [2:0] {
    SAG_REF_FETCH = 3'h0,
    SAG_REF_PUSH  = 3'h1,
    SAG_REF_POP   = 3'h2,
    SAG_REF_SDST  = 3'h3,
    SAG_REF_DATA  = 3'h4
  } sag_ref_t;
endpackage

/* File: hdl/sag_seg_select.sv */
// Default segment choice and override handling
`timescale 1ns/1ns
`default_nettype none
`include "sag_regs.svh"
module sag_seg_select
  import sag_pkg::*;
(
  // Reference description
  input  wire logic [2:0] ref_kind,
  input  wire logic       base_en,
  input  wire logic [2:0] base_sel,
  input  wire logic       addr32,
  // Override prefix
  input  wire logic       ovr_en,
  input  wire logic [2:0] ovr_seg,
  // Chosen segment
  output logic [2:0]      seg_sel
);
  logic stack_base;

  // Frame pointer as base selects the stack segment; stack pointer too with 32-bit addressing
  always_comb
  begin
    if (addr32)
      stack_base = base_en && ((base_sel == `SAG_GPR_BP) || (base_sel == `SAG_GPR_SP));
    else
      stack_base = base_en && (base_sel == `SAG_GPR_BP);
  end

  // Fixed references ignore any override prefix
  always_comb
  begin
    unique case (sag_ref_t'(ref_kind))
      SAG_REF_FETCH: seg_sel = SAG_SEG_CODE;
      SAG_REF_PUSH,
      SAG_REF_POP:   seg_sel = SAG_SEG_STACK;
      SAG_REF_SDST:  seg_sel = SAG_SEG_EXTRA;
      SAG_REF_DATA:
      begin
        if (ovr_en && (ovr_seg <= SAG_SEG_AUX2))
          seg_sel = ovr_seg;
        else if (stack_base)
          seg_sel = SAG_SEG_STACK;
        else
          seg_sel = SAG_SEG_DATA;
      end
      default:       seg_sel = SAG_SEG_DATA;
    endcase
  end
endmodule
`default_nettype wire

/* File: hdl/sag_offset_calc.sv */
// Effective offset sum with scaling, displacement and size wrap
`timescale 1ns/1ns
`default_nettype none
`include "sag_regs.svh"
module sag_offset_calc
(
  // Components
  input  wire logic        base_en,
  input  wire logic [31:0] base_val,
  input  wire logic        index_en,
  input  wire logic [2:0]  index_sel,
  input  wire logic [31:0] index_val,
  input  wire logic [1:0]  scale_log2,
  input  wire logic [1:0]  disp_size,
  input  wire logic [31:0] disp_val,
  input  wire logic        addr32,
  // Result
  output logic [31:0]      effective_offset,
  output logic             form_bad
);
  logic [31:0] base_term;
  logic [31:0] index_term;
  logic [31:0] disp_term;
  logic [31:0] sum;

  // Operand terms; an absent term counts as zero
  always_comb
  begin
    base_term  = base_en ? base_val : 32'h00000000;
    index_term = 32'h00000000;
    if (index_en)
      index_term = addr32 ? (index_val << scale_log2)
                          : {16'h0000, index_val[15:0]};
    unique case (disp_size)
      2'h0: disp_term = 32'h00000000;
      2'h1: disp_term = {{24{disp_val[7]}}, disp_val[7:0]};
      2'h2: disp_term = {{16{disp_val[15]}}, disp_val[15:0]};
      2'h3: disp_term = disp_val;
    endcase
    if (!addr32)
      base_term = {16'h0000, base_val[15:0]} & {32{base_en}};
    sum = base_term + index_term + disp_term;
    effective_offset = addr32 ? sum : {16'h0000, sum[15:0]};
    // Illegal register or width combinations for the active size
    if (addr32)
      form_bad = (index_en && (index_sel == `SAG_GPR_SP)) ||
                 (disp_size == 2'h2);
    else
      form_bad = (disp_size == 2'h3) || (scale_log2 != 2'h0);
  end
endmodule
`default_nettype wire

/* File: tb/sag_asserts.sv */
// Port-level checks for the segmented address generator
`timescale 1ns/1ns
`default_nettype none
module sag_asserts
  import sag_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // Request side
  input wire logic        real_mode,
  input wire logic [31:0] ctrl_reg0,
  input wire logic        ovr_en,
  input wire logic [2:0]  ovr_seg,
  input wire logic        req_valid,
  input wire logic [2:0]  ref_kind,
  input wire logic        base_en,
  input wire logic        index_en,
  // Result side
  input wire logic        req_ready,
  input wire logic        out_valid,
  input wire logic [2:0]  out_seg,
  input wire logic [31:0] out_linear,
  input wire logic [23:0] out_phys,
  input wire logic        out_to_pager
);
  // Accepts split by latency; fetches never take the slow path
  logic tk1;
  logic tk2;
  assign tk1 = req_valid && req_ready && !(base_en && index_en);
  assign tk2 = req_valid && req_ready && base_en && index_en && ref_kind != 3'h0;
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_answer_next: assert property (tk1 |=> out_valid)
    else $error("single clock answer missing");
  a_extra_clock: assert property (tk2 |=> !out_valid && !req_ready ##1 out_valid && req_ready)
    else $error("base plus index timing wrong");
  a_phys_trunc: assert property (out_valid |-> out_phys == out_linear[23:0])
    else $error("physical address not low linear bits");
  a_fetch_code: assert property (tk1 && ref_kind == 3'h0 |=> out_seg == SAG_SEG_CODE)
    else $error("fetch not on code segment");
  a_stack_kinds: assert property (tk1 && ref_kind inside {3'h1, 3'h2} |=> out_seg == SAG_SEG_STACK)
    else $error("stack reference redirected");
  a_string_dest: assert property (tk1 && ref_kind == 3'h3 |=> out_seg == SAG_SEG_EXTRA)
    else $error("string destination not extra segment");
  a_override_use: assert property (tk1 && ref_kind == 3'h4 && ovr_en && ovr_seg < 3'h6
    |=> out_seg == $past(ovr_seg))
    else $error("override ignored on data reference");
  a_pager_path: assert property (tk1 && !real_mode |=> out_to_pager == $past(ctrl_reg0[31]))
    else $error("pager path does not follow enable bit");
endmodule
bind sag_top sag_asserts i_chk (.core_clk, .srst, .real_mode, .ctrl_reg0, .ovr_en, .ovr_seg,
  .req_valid, .ref_kind, .base_en, .index_en, .req_ready, .out_valid, .out_seg, .out_linear,
  .out_phys, .out_to_pager);
`default_nettype wire

/* File: tb/sag_pipe_model.sv */
// Pipeline-side model that issues requests and times the answers
`timescale 1ns/1ns
`default_nettype none
module sag_pipe_model
(
  // Clock and handshake
  input  wire logic core_clk,
  input  wire logic req_ready,
  input  wire logic out_valid,
  output var logic  req_valid
);
  initial req_valid = 1'b0;
  // Hold the request until an edge sees ready; lat is set to -1 on a hang
  task automatic issue(output int lat);
    logic rdy;
    int   n;
    n = 0;
    @(posedge core_clk);
    #1 req_valid = 1'b1;
    do
    begin
      rdy = req_ready;
      @(posedge core_clk);
      n++;
      if (!rdy)
        #1;
    end
    while (!rdy && n < 20);
    #1 req_valid = 1'b0;
    lat = 1;
    while (!out_valid && lat < 8)
    begin
      @(posedge core_clk);
      #1 lat++;
    end
    if (!rdy || !out_valid)
      lat = -1;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the segmented address generator
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sag_pkg::*;
  // Stimulus
  logic         core_clk, srst, real_mode, desc_default_big, op_len_prefix;
  logic         addr_len_prefix, ovr_en, req_valid, base_en, index_en;
  logic [2:0]   ovr_seg, ref_kind, base_sel, index_sel;
  logic [1:0]   scale_log2, disp_size;
  logic [31:0]  ctrl_reg0, instr_ptr, base_val, index_val, disp_val, e;
  logic [191:0] seg_base_flat;
  logic [95:0]  seg_selector_flat;
  // Results
  logic         req_ready, out_valid, out_to_pager, out_gp_fault, out_form_bad;
  logic         out_op32, out_addr32;
  logic [2:0]   out_seg;
  logic [31:0]  out_offset, out_linear;
  logic [23:0]  out_phys;
  int           err_total = 0;
  int           check_count = 0;
  int           lat;
  logic [8:0]   bad_tbl [5] = '{9'h1C1, 9'h102, 9'h003, 9'h0E5, 9'h0E2};
  sag_top i_dut (.*);
  sag_pipe_model i_pipe (.core_clk, .req_ready, .out_valid, .req_valid);
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  function automatic logic [31:0] sb(input int g);
    return seg_base_flat[g*32+:32];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One request; a hung handshake ends the run at once
  task automatic go(input logic [2:0] kind);
    ref_kind = kind;
    i_pipe.issue(lat);
    if (lat < 0)
    begin
      err_total++;
      summarize();
    end
  endtask
  task automatic t_fetch();
    {ovr_en, ovr_seg, instr_ptr} = {4'hB, 32'h00AB_CDEF};
    go(3'h0);
    chk(out_seg, 32'h1);
    chk(out_linear, sb(1) + instr_ptr);
    chk(out_phys, (sb(1) + instr_ptr) & 32'h00FF_FFFF);
    chk(out_to_pager, 32'h0);
  endtask
  // Six forms at four scales, with 32-bit wrap and paging on
  task automatic t_forms();
    {ovr_en, desc_default_big, ctrl_reg0} = {2'h1, 32'h8000_0000};
    {base_sel, index_sel, base_val, index_val} = {6'h1E, 32'hFFFF_FFF0, 32'h0000_0101};
    disp_val = 32'h8000_0004;
    for (int f = 0; f < 6; f++)
      for (int s = 0; s < 4; s++)
      begin
        base_en = f inside {1, 2, 4, 5};
        index_en = f > 2;
        disp_size = (f == 1 || f == 4) ? 2'h0 : 2'h3;
        scale_log2 = s[1:0];
        e = (base_en ? base_val : 0) + (index_en ? index_val << s : 0) + (f != 1 && f != 4 ? disp_val : 0);
        go(3'h4);
        chk(lat, base_en && index_en ? 2 : 1);
        chk(out_offset, e);
        chk(out_linear, sb(3) + e);
        chk({out_to_pager, out_form_bad}, 32'h2);
      end
  endtask
  // Implied segments resist every override; data follows it
  task automatic t_segs();
    {ovr_en, base_en, index_en} = 3'h6;
    for (int k = 0; k < 6; k++)
      for (int r = 0; r < 5; r++)
      begin
        ovr_seg = k[2:0];
        go(r[2:0]);
        e = r == 0 ? 1 : r < 3 ? 2 : r == 3 ? 0 : k;
        chk(out_seg, e);
      end
    ovr_en = 1'b0;
    for (int b = 3; b < 6; b++)
    begin
      base_sel = b[2:0];
      go(3'h4);
      chk(out_seg, b == 3 ? 3 : 2);
    end
  endtask
  task automatic t_sizes();
    {base_en, disp_size, disp_val} = {3'h1, 32'h10};
    for (int m = 0; m < 16; m++)
    begin
      {real_mode, desc_default_big, op_len_prefix, addr_len_prefix} = m[3:0];
      go(3'h4);
      e = (!m[3] && m[2]) ? 3 : 0;
      chk({out_op32, out_addr32}, e ^ m[1:0]);
    end
  endtask
  // Real mode: selector times sixteen, no paging, past 64K faults
  task automatic t_real();
    {real_mode, desc_default_big, op_len_prefix} = 3'h4;
    {base_en, base_sel, base_val, disp_val} = {4'hB, 32'h0000_FFF0, 32'h20};
    for (int p = 0; p < 2; p++)
    begin
      addr_len_prefix = p[0];
      go(3'h4);
      e = p ? 32'h0001_0010 : 32'h0000_0010;
      chk(out_offset, e);
      chk(out_linear, {seg_selector_flat[63:48], 4'h0} + e);
      chk({out_to_pager, out_gp_fault}, p);
    end
  endtask
  // Illegal forms flagged per address size; last entry is legal
  task automatic t_bad();
    {real_mode, addr_len_prefix} = 2'h0;
    for (int c = 0; c < 5; c++)
    begin
      {desc_default_big, index_en, index_sel, scale_log2, disp_size} = bad_tbl[c];
      go(3'h4);
      chk(out_form_bad, c < 4);
    end
  endtask
  initial
  begin
    {srst, real_mode, desc_default_big, op_len_prefix, addr_len_prefix} = 5'h10;
    {ovr_en, base_en, index_en, ovr_seg, ref_kind, base_sel, index_sel} = '0;
    {scale_log2, disp_size, ctrl_reg0, instr_ptr, base_val, index_val, disp_val, e} = '0;
    for (int g = 0; g < 6; g++)
    begin
      seg_base_flat[g*32+:32] = 32'h1100_0010 * (g + 1);
      seg_selector_flat[g*16+:16] = 16'h0120 + 16'(g);
    end
    repeat (16) @(posedge core_clk);
    #1 srst = 1'b0;
    t_fetch();
    t_forms();
    t_segs();
    t_sizes();
    t_real();
    t_bad();
    summarize();
  end
endmodule
`default_nettype wire
